// >>> common/cdx_pkg.sv
package cdx_pkg;
	// clock and command word geometry
	localparam int CLK_HZ = 25_000_000;
	localparam int CMD_W = 8;
	localparam int RX_N = 4;
	localparam int RELAY_N = 60;
	localparam int PULSE_N = 50;

	// decoder addresses; values are arbitrary
	localparam logic [CMD_W-1:0] ADDR_CH0 = 8'h5A;
	localparam logic [CMD_W-1:0] ADDR_CH1 = 8'hA5;

	// excluded codes
	localparam logic [CMD_W-1:0] CMD_ZEROS = 8'h00;
	localparam logic [CMD_W-1:0] CMD_ONES = 8'hFF;

	// command map: relay pairs, pulses, then specials
	localparam logic [CMD_W-1:0] CMD_RELAY_FIRST = 8'h01;
	localparam logic [CMD_W-1:0] CMD_RELAY_LAST = 8'h78;
	localparam logic [CMD_W-1:0] CMD_PULSE_FIRST = 8'h79;
	localparam logic [CMD_W-1:0] CMD_PULSE_LAST = 8'hAA;
	localparam logic [CMD_W-1:0] CMD_ARM = 8'hAB;
	localparam logic [CMD_W-1:0] CMD_FIRE = 8'hAC;
	localparam logic [CMD_W-1:0] CMD_TLM_MOD_OFF = 8'hAD;
	localparam logic [CMD_W-1:0] CMD_TLM_MOD_ON = 8'hAE;
	localparam logic [CMD_W-1:0] CMD_RANGING_OFF = 8'hAF;

	// timing
	localparam int MEAS_US = 20;
	localparam int MEAS_CYC = (MEAS_US * (CLK_HZ / 1_000_000));
	localparam int FIRE_MIN_MS = 500;
	localparam int FIRE_MIN_CYC = FIRE_MIN_MS * (CLK_HZ / 1000);
	localparam int EXEC_CNT_W = 24;

	// reset values
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic TLM_MOD_RST = 1'b1;

	typedef enum logic [1:0] {
		CDX_STANDBY = 2'b00,
		CDX_ADDRESSED = 2'b01,
		CDX_HOLDING = 2'b10,
		CDX_EXECUTING = 2'b11
	} cdx_state_t;
endpackage

// >>> design/cdx_command_unit.sv
`timescale 1ns/10ps
// Notes on behaviour
// - each decoder answers only its own address, else returns to standby
// - no tone on sampled receiver: step to next receiver, measure again
// - addressed decoder captures the following command number and holds it
// - held number is placed in the telemetry main-frame command word
// - command acts only on execute tone; held number alone drives nothing
// - execute tone sets one stored bit in a telemetry main-frame word
// - real-time telemetry shows the execute tone for its whole duration
// - both decoder channels merge into one output per command function
// - latching relay outputs, each set by one command, cleared by another
// - momentary pulse outputs asserted only while their command executes
// - at most 254 commands; all-zeros and all-ones codes never valid
// - fire is blocked unless the arm command executed beforehand
// - fire needs an execute tone clearly longer than ordinary tones
// - ranging address tone switches on ranging mode in both receivers
// - holding tone in ranging mode unsquelches receiver path to transmitter
// - holding tone selects the alternative telemetry modulation index
// - commands switch telemetry modulation off and back on
module cdx_command_unit import cdx_pkg::*; #(
	parameter int FIRE_CYC = FIRE_MIN_CYC
) (
	input wire logic clk, // 25 MHz clock
	input wire logic resetn, // async reset, active low
	input wire logic [RX_N-1:0] rx_tone_pin, // tone detected per receiver
	input wire logic exec_tone_pin, // execute tone detected
	input wire logic range_addr_pin, // ranging address tone detected
	input wire logic hold_tone_pin, // 4 kHz holding tone detected
	input wire logic addr_stb, // demodulated address valid
	input wire logic [CMD_W-1:0] addr, // demodulated address
	input wire logic num_stb, // demodulated number valid
	input wire logic [CMD_W-1:0] num, // demodulated command number
	input wire logic tlm_word_taken, // telemetry frame read the exec bit
	output logic [3:0] sampler_sel, // ch1 and ch0 receiver selects
	output logic [CMD_W-1:0] tlm_cmd_word, // main-frame command number word
	output logic tlm_cmd_valid, // main-frame word holds a number
	output logic tlm_exec_bit, // stored evidence of execute tone
	output logic rt_exec_tone, // real-time execute tone indication
	output logic [RELAY_N-1:0] relay_out, // latching relay states
	output logic [PULSE_N-1:0] pulse_out, // momentary command pulses
	output logic armed, // arm command has executed
	output logic fire_out, // fire pulse
	output logic [1:0] ranging_en, // ranging mode, both receivers
	output logic if_unsquelch, // receiver if path to transmitter open
	output logic tlm_mod_alt, // alternative modulation index
	output logic tlm_mod_en // telemetry modulation on
);
	localparam int SYN_W = RX_N + 3;
	logic rst_m;
	logic rst_n;
	logic [SYN_W-1:0] sy1;
	logic [SYN_W-1:0] sy2;
	logic [SYN_W-1:0] sy3;
	logic [SYN_W-1:0] pin_q;
	logic [1:0] ch_valid;
	logic [1:0] ch_active;
	logic [1:0] ch_start;
	logic [1:0] ch_long;
	logic [CMD_W-1:0] ch_num [2];
	logic [1:0] ch_sel [2];
	wire [SYN_W-1:0] pin_raw = {hold_tone_pin, range_addr_pin, exec_tone_pin, rx_tone_pin};
	wire [RX_N-1:0] rx_tone = pin_q[RX_N-1:0];
	wire exec_tone = pin_q[RX_N];
	wire range_tone = pin_q[RX_N+1];
	wire hold_tone = pin_q[RX_N+2];

	// reset release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	// pin synchronisers: a level counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1 <= '0;
			sy2 <= '0;
			sy3 <= '0;
			pin_q <= '0;
		end else begin
			sy1 <= pin_raw;
			sy2 <= sy1;
			sy3 <= sy2;
			pin_q <= (sy2 & sy3) | (pin_q & (sy2 | sy3));
		end
	end

	// two redundant decoders with distinct addresses
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			cdx_decoder #(
				.OWN_ADDR(g == 0 ? ADDR_CH0 : ADDR_CH1),
				.FIRE_CYC(FIRE_CYC)
			) u_dec (
				.clk(clk),
				.rst_n(rst_n),
				.rx_tone(rx_tone),
				.addr_stb(addr_stb),
				.addr(addr),
				.num_stb(num_stb),
				.num(num),
				.exec_tone(exec_tone),
				.sel(ch_sel[g]),
				.held_valid(ch_valid[g]),
				.held_num(ch_num[g]),
				.exec_active(ch_active[g]),
				.exec_start(ch_start[g]),
				.exec_long(ch_long[g])
			);
		end
	endgenerate

	// channel merge: the channel holding a number drives the outputs, ch0 when both do
	wire use_ch1 = !ch_valid[0] && ch_valid[1];
	wire [CMD_W-1:0] m_num = use_ch1 ? ch_num[1] : ch_num[0];
	wire m_valid = |ch_valid;
	wire m_active = use_ch1 ? ch_active[1] : ch_active[0];
	wire m_start = use_ch1 ? ch_start[1] : ch_start[0];
	wire m_long = use_ch1 ? ch_long[1] : ch_long[0];

	// command decode of the executing number
	function automatic logic in_range(input logic [CMD_W-1:0] n,
			input logic [CMD_W-1:0] lo, input logic [CMD_W-1:0] hi);
		in_range = (n >= lo) && (n <= hi);
	endfunction
	wire is_relay = in_range(m_num, CMD_RELAY_FIRST, CMD_RELAY_LAST);
	wire is_pulse = in_range(m_num, CMD_PULSE_FIRST, CMD_PULSE_LAST);
	wire [CMD_W-1:0] relay_off = m_num - CMD_RELAY_FIRST;
	wire [CMD_W-1:0] pulse_idx = m_num - CMD_PULSE_FIRST;
	wire relay_set = !relay_off[0]; // odd numbers set, even clear
	wire [CMD_W-1:0] relay_idx = {1'b0, relay_off[CMD_W-1:1]};
	wire do_fire = m_active && (m_num == CMD_FIRE) && m_long && armed;
	wire go = m_start; // one cycle per execution

	// relay outputs hold state until the opposite command of the pair
	generate
		for (g = 0; g < RELAY_N; g++) begin : gen_relay
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) relay_out[g] <= 1'b0;
				else if (go && is_relay && relay_idx == CMD_W'(g)) relay_out[g] <= relay_set;
			end
		end
		for (g = 0; g < PULSE_N; g++) begin : gen_pulse
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) pulse_out[g] <= 1'b0;
				else pulse_out[g] <= m_active && is_pulse && pulse_idx == CMD_W'(g);
			end
		end
	endgenerate

	// arm, fire, telemetry modulation and ranging control
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
			fire_out <= 1'b0;
			tlm_mod_en <= TLM_MOD_RST;
			ranging_en <= 2'h0;
			if_unsquelch <= 1'b0;
			tlm_mod_alt <= 1'b0;
		end else begin
			fire_out <= do_fire;
			// arm is spent once a fire has ended
			if (go && m_num == CMD_ARM) armed <= 1'b1;
			else if (fire_out && !do_fire) armed <= 1'b0;
			if (go && m_num == CMD_TLM_MOD_OFF) tlm_mod_en <= 1'b0;
			else if (go && m_num == CMD_TLM_MOD_ON) tlm_mod_en <= 1'b1;
			if (range_tone) ranging_en <= 2'h3;
			else if (go && m_num == CMD_RANGING_OFF) ranging_en <= 2'h0;
			if_unsquelch <= ranging_en[0] && hold_tone;
			tlm_mod_alt <= hold_tone;
		end
	end

	// telemetry reporting; a new execute beats a same-cycle read clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tlm_cmd_word <= CMD_ZEROS;
			tlm_cmd_valid <= 1'b0;
			tlm_exec_bit <= 1'b0;
			rt_exec_tone <= 1'b0;
			sampler_sel <= 4'h0;
		end else begin
			tlm_cmd_word <= m_valid ? m_num : CMD_ZEROS;
			tlm_cmd_valid <= m_valid;
			if (go) tlm_exec_bit <= 1'b1;
			else if (tlm_word_taken) tlm_exec_bit <= 1'b0;
			rt_exec_tone <= exec_tone;
			sampler_sel <= {ch_sel[1], ch_sel[0]};
		end
	end
endmodule

// >>> design/cdx_decoder.sv
`timescale 1ns/10ps
module cdx_decoder import cdx_pkg::*; #(
	parameter logic [CMD_W-1:0] OWN_ADDR = ADDR_CH0,
	parameter int FIRE_CYC = FIRE_MIN_CYC
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset
	input wire logic [RX_N-1:0] rx_tone, // tone present per receiver
	input wire logic addr_stb, // address word valid
	input wire logic [CMD_W-1:0] addr, // address word
	input wire logic num_stb, // command number valid
	input wire logic [CMD_W-1:0] num, // command number
	input wire logic exec_tone, // execute tone level
	output logic [1:0] sel, // receiver being sampled
	output logic held_valid, // a command number is held
	output logic [CMD_W-1:0] held_num, // held command number
	output logic exec_active, // execute tone acting on held command
	output logic exec_start, // first cycle of execution
	output logic exec_long // tone long enough for fire
);
	cdx_state_t state;
	cdx_state_t next_state;
	logic [15:0] meas_cnt;
	logic [EXEC_CNT_W-1:0] exec_cnt;
	wire locked = rx_tone[sel];
	wire meas_done = (meas_cnt == 16'(MEAS_CYC - 1));
	wire own_addr = (addr == OWN_ADDR);
	wire num_ok = (num != CMD_ZEROS) && (num != CMD_ONES);
	wire long_hit = (exec_cnt >= EXEC_CNT_W'(FIRE_CYC - 1));

	// sampler steps on when the selected receiver shows no tone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel <= SEL_RST;
			meas_cnt <= '0;
		end else if (locked) begin
			meas_cnt <= '0;
		end else if (meas_done) begin
			sel <= sel + 2'h1;
			meas_cnt <= '0;
		end else begin
			meas_cnt <= meas_cnt + 16'h1;
		end
	end

	// losing the tone drops any partial message back to standby
	always_comb begin
		next_state = state;
		if (!locked) begin
			next_state = CDX_STANDBY;
		end else begin
			case (state)
				CDX_STANDBY: begin
					if (addr_stb && own_addr) next_state = CDX_ADDRESSED;
				end
				CDX_ADDRESSED: begin
					if (addr_stb && !own_addr) next_state = CDX_STANDBY;
					else if (num_stb) next_state = num_ok ? CDX_HOLDING : CDX_STANDBY;
				end
				CDX_HOLDING: begin
					if (addr_stb) next_state = own_addr ? CDX_ADDRESSED : CDX_STANDBY;
					else if (exec_tone) next_state = CDX_EXECUTING;
				end
				CDX_EXECUTING: begin
					if (!exec_tone) next_state = CDX_STANDBY;
				end
				default: next_state = CDX_STANDBY;
			endcase
		end
	end

	// number capture and execute-tone length measurement
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= CDX_STANDBY;
			held_num <= CMD_ZEROS;
			exec_cnt <= '0;
			exec_start <= 1'b0;
			exec_long <= 1'b0;
		end else begin
			state <= next_state;
			exec_start <= (state == CDX_HOLDING) && (next_state == CDX_EXECUTING);
			if (state == CDX_ADDRESSED && next_state == CDX_HOLDING) held_num <= num;
			if (next_state != CDX_EXECUTING) begin
				exec_cnt <= '0;
				exec_long <= 1'b0;
			end else begin
				if (!long_hit) exec_cnt <= exec_cnt + EXEC_CNT_W'(1);
				exec_long <= long_hit;
			end
		end
	end

	assign held_valid = (state == CDX_HOLDING) || (state == CDX_EXECUTING);
	assign exec_active = (state == CDX_EXECUTING);
endmodule

// >>> sim/cdx_command_unit_asserts.sv
`timescale 1ns/10ps
module cdx_command_unit_asserts import cdx_pkg::*; #(
	parameter int FIRE_CYC = FIRE_MIN_CYC
) (
	input wire logic clk, // clock
	input wire logic resetn, // raw reset
	input wire logic exec_tone_pin, // tone pin
	input wire logic range_addr_pin, // ranging pin
	input wire logic hold_tone_pin, // holding pin
	input wire logic [CMD_W-1:0] tlm_cmd_word, // held word
	input wire logic tlm_cmd_valid, // word valid
	input wire logic tlm_exec_bit, // exec evidence
	input wire logic rt_exec_tone, // real-time tone
	input wire logic [RELAY_N-1:0] relay_out, // relays
	input wire logic [PULSE_N-1:0] pulse_out, // pulses
	input wire logic armed, // arm state
	input wire logic fire_out, // fire
	input wire logic [1:0] ranging_en, // ranging
	input wire logic if_unsquelch, // if path
	input wire logic tlm_mod_alt // alt index
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// pin paths pass a 4-flop synchroniser, so windows allow a few edges
	rt_rise_a: assert property ($rose(exec_tone_pin) |-> ##[2:8] rt_exec_tone)
		else $error("real-time tone indication missing");
	exec_bit_a: assert property ($rose(rt_exec_tone) && tlm_cmd_valid |-> ##[0:4] tlm_exec_bit)
		else $error("exec evidence bit not set");
	relay_exec_a: assert property ($changed(relay_out) |-> rt_exec_tone && tlm_exec_bit)
		else $error("relay moved without execution");
	pulse_exec_a: assert property (|pulse_out |-> rt_exec_tone || $past(rt_exec_tone))
		else $error("pulse outside execution");
	fire_arm_a: assert property ($rose(fire_out) |-> armed)
		else $error("fire without arm");
	// run length of the real-time tone, saturating so it never wraps on long tones
	int tone_run;
	always_ff @(posedge clk) begin
		if (!resetn || !rt_exec_tone) tone_run <= 0;
		else if (tone_run < FIRE_CYC) tone_run <= tone_run + 1;
	end
	fire_len_a: assert property ($rose(fire_out) |-> tone_run >= FIRE_CYC - 1)
		else $error("fire on short tone");
	range_on_a: assert property ($rose(range_addr_pin) |-> ##[2:8] ranging_en == 2'h3)
		else $error("ranging mode not enabled");
	unsq_only_a: assert property (if_unsquelch |-> $past(ranging_en) == 2'h3)
		else $error("unsquelch outside ranging");
	mod_alt_a: assert property ($rose(hold_tone_pin) |-> ##[2:8] tlm_mod_alt)
		else $error("alt modulation not selected");
	hold_code_a: assert property (tlm_cmd_valid |-> tlm_cmd_word != CMD_ZEROS && tlm_cmd_word != CMD_ONES)
		else $error("excluded code held");
	cover property ($rose(fire_out));
	cover property ($rose(|pulse_out));
	cover property ($rose(if_unsquelch));
endmodule

bind cdx_command_unit cdx_command_unit_asserts #(.FIRE_CYC(FIRE_CYC)) i_chk (
	.clk(clk), .resetn(resetn), .exec_tone_pin(exec_tone_pin),
	.range_addr_pin(range_addr_pin), .hold_tone_pin(hold_tone_pin),
	.tlm_cmd_word(tlm_cmd_word), .tlm_cmd_valid(tlm_cmd_valid), .tlm_exec_bit(tlm_exec_bit),
	.rt_exec_tone(rt_exec_tone), .relay_out(relay_out), .pulse_out(pulse_out), .armed(armed),
	.fire_out(fire_out), .ranging_en(ranging_en), .if_unsquelch(if_unsquelch),
	.tlm_mod_alt(tlm_mod_alt));

// >>> sim/cdx_command_unit_tb.sv
`timescale 1ns/10ps
module cdx_command_unit_tb import cdx_pkg::*;;
	logic clk = 1'b0;
	logic resetn, range_addr_pin, hold_tone_pin, tlm_word_taken, exec_tone_pin;
	logic [RX_N-1:0] rx_tone_pin;
	logic addr_stb, num_stb, tlm_cmd_valid, tlm_exec_bit, rt_exec_tone, armed, fire_out;
	logic if_unsquelch, tlm_mod_alt, tlm_mod_en;
	logic [CMD_W-1:0] addr, num, tlm_cmd_word;
	logic [3:0] sampler_sel;
	logic [1:0] ranging_en;
	logic [RELAY_N-1:0] relay_out;
	logic [PULSE_N-1:0] pulse_out, pulse_seen = '0;
	logic [CMD_W-1:0] exp_q[$];
	int err_count = 0, check_count = 0, n, rt_len = 0;
	bit seen, fired = 1'b0;
	always #20 clk = ~clk;
	// short fire threshold keeps the run brief
	cdx_command_unit #(.FIRE_CYC(50)) i_dut (.clk(clk), .resetn(resetn),
		.rx_tone_pin(rx_tone_pin), .exec_tone_pin(exec_tone_pin), .range_addr_pin(range_addr_pin),
		.hold_tone_pin(hold_tone_pin), .addr_stb(addr_stb), .addr(addr), .num_stb(num_stb),
		.num(num), .tlm_word_taken(tlm_word_taken), .sampler_sel(sampler_sel),
		.tlm_cmd_word(tlm_cmd_word), .tlm_cmd_valid(tlm_cmd_valid), .tlm_exec_bit(tlm_exec_bit),
		.rt_exec_tone(rt_exec_tone), .relay_out(relay_out), .pulse_out(pulse_out), .armed(armed),
		.fire_out(fire_out), .ranging_en(ranging_en), .if_unsquelch(if_unsquelch),
		.tlm_mod_alt(tlm_mod_alt), .tlm_mod_en(tlm_mod_en));
	cdx_ground_station i_gnd (.clk(clk), .tlm_cmd_word(tlm_cmd_word),
		.tlm_cmd_valid(tlm_cmd_valid), .addr_stb(addr_stb), .addr(addr), .num_stb(num_stb),
		.num(num), .exec_tone(exec_tone_pin));
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a report with nothing expected compares against an impossible word
	always @(posedge tlm_cmd_valid) begin
		#1;
		check(tlm_cmd_word, exp_q.size() ? exp_q.pop_front() : 9'h1EE);
	end
	// sticky observers of short-lived outputs
	always @(posedge clk) pulse_seen <= pulse_seen | pulse_out;
	// cycles of real-time tone indication seen so far
	always @(posedge clk) if (rt_exec_tone) rt_len <= rt_len + 1;
	always @(posedge fire_out) fired = 1'b1;
	task automatic cmd(input logic [CMD_W-1:0] a, input logic [CMD_W-1:0] c, input int len);
		if ((a == ADDR_CH0 || a == ADDR_CH1) && c != CMD_ZEROS && c != CMD_ONES)
			exp_q.push_back(c);
		i_gnd.send(a, c, len, 1'b0, seen);
	endtask
	task automatic pin_pulse(ref logic p);
		p = 1'b1;
		repeat (6) @(negedge clk);
		p = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	initial begin
		resetn = 1'b0;
		rx_tone_pin = 4'hF;
		range_addr_pin = 1'b0;
		hold_tone_pin = 1'b0;
		tlm_word_taken = 1'b0;
		void'($urandom(11));
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		repeat (8) @(negedge clk);
		check({relay_out, armed, fire_out, tlm_mod_en, tlm_cmd_valid}, 4'h2);
		cmd(ADDR_CH0, 8'h01, 10);
		check(relay_out, 1);
		check(rt_len, 10);
		cmd(ADDR_CH1, 8'h02, 10);
		check({tlm_exec_bit, relay_out}, 61'h1 << 60);
		pin_pulse(tlm_word_taken);
		check(tlm_exec_bit, 0);
		i_gnd.send(8'h33, 8'h03, 10, 1'b1, seen);
		i_gnd.send(ADDR_CH0, CMD_ZEROS, 10, 1'b1, seen);
		i_gnd.send(ADDR_CH0, CMD_ONES, 10, 1'b1, seen);
		check({tlm_exec_bit, relay_out, pulse_seen}, 0);
		cmd(ADDR_CH0, CMD_PULSE_LAST, 10);
		check({pulse_seen, pulse_out}, 100'h1 << 99);
		// fire refused unarmed, then refused on short tone, then taken
		cmd(ADDR_CH0, CMD_FIRE, 80);
		check({fired, armed}, 0);
		cmd(ADDR_CH1, CMD_ARM, 10);
		cmd(ADDR_CH0, CMD_FIRE, 20);
		check({fired, armed}, 1);
		cmd(ADDR_CH0, CMD_FIRE, 80);
		check({fired, armed}, 2);
		cmd(ADDR_CH0, CMD_TLM_MOD_OFF, 10);
		check(tlm_mod_en, 0);
		cmd(ADDR_CH1, CMD_TLM_MOD_ON, 10);
		check(tlm_mod_en, 1);
		pin_pulse(range_addr_pin);
		hold_tone_pin = 1'b1;
		repeat (8) @(negedge clk);
		check({ranging_en, if_unsquelch, tlm_mod_alt}, 4'hF);
		cmd(ADDR_CH0, CMD_RANGING_OFF, 10);
		check({ranging_en, if_unsquelch, tlm_mod_alt}, 4'h1);
		hold_tone_pin = 1'b0;
		repeat (3) begin
			n = $urandom % RELAY_N;
			cmd(ADDR_CH1, CMD_W'(2 * n + 1), 10);
			check({relay_out[n], tlm_mod_alt}, 2);
		end
		cmd(ADDR_CH0, CMD_W'(2 * n + 2), 10);
		check(relay_out[n], 0);
		// dropping receiver 0 makes both samplers move on to receiver 1
		rx_tone_pin = 4'hE;
		for (int i = 0; i < 600 && sampler_sel !== 4'h5; i++)
			@(negedge clk);
		check({sampler_sel, exp_q.size()}, 36'h5 << 32);
		final_report();
	end
endmodule

// >>> sim/cdx_ground_station.sv
`timescale 1ns/10ps
module cdx_ground_station import cdx_pkg::*; (
	input wire logic clk, // system clock
	input wire logic [CMD_W-1:0] tlm_cmd_word, // reported number
	input wire logic tlm_cmd_valid, // report present
	output logic addr_stb = 1'b0, // address strobe
	output logic [CMD_W-1:0] addr = 8'h00, // address word
	output logic num_stb = 1'b0, // number strobe
	output logic [CMD_W-1:0] num = 8'h00, // command number
	output logic exec_tone = 1'b0 // execute tone
);
	// released words show the inverse, so stale values never match
	task automatic send(input logic [CMD_W-1:0] a, input logic [CMD_W-1:0] n,
			input int len, input bit force_tone, output bit seen);
		@(negedge clk);
		addr_stb = 1'b1;
		addr = a;
		@(negedge clk);
		addr_stb = 1'b0;
		addr = ~a;
		num_stb = 1'b1;
		num = n;
		@(negedge clk);
		num_stb = 1'b0;
		num = ~n;
		seen = 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			if (tlm_cmd_valid === 1'b1 && tlm_cmd_word === n)
				seen = 1'b1;
		end
		// after four watched cycles the tone goes out if the report matched, or anyway when force_tone is set
		if (seen || force_tone) begin
			exec_tone = 1'b1;
			repeat (len) @(negedge clk);
			exec_tone = 1'b0;
		end
		repeat (12) @(negedge clk);
	endtask
endmodule
